// file: shared/eoc_pkg.sv
// Purpose: constants and types for the external oscillator control block
// Assumes: 8-bit control register on a plain strobe port
// Notes: interrupt registers sit three and four offsets above the control register
package eoc_pkg;

	localparam int unsigned eoc_addr_w = 8;
	localparam int unsigned eoc_data_w = 8;

	// register offsets
	localparam logic [7:0] eoc_off_ctrl = 8'hb1;
	localparam logic [7:0] eoc_off_irq_stat = 8'hb4;
	localparam logic [7:0] eoc_off_irq_mask = 8'hb5;

	// control register fields
	localparam int unsigned eoc_valid_bit = 7;
	localparam int unsigned eoc_mode_lsb = 4;
	localparam int unsigned eoc_rsvd_bit = 3;
	localparam int unsigned eoc_bias_lsb = 0;

	// reset values
	localparam logic [7:0] eoc_ctrl_rst = 8'h00;
	localparam logic [2:0] eoc_mode_rst = 3'h0;
	localparam logic [2:0] eoc_bias_rst = 3'h0;
	localparam logic [1:0] eoc_irq_rst = 2'h0;

	// interrupt status bits
	localparam int unsigned eoc_irq_valid_rise = 0;
	localparam int unsigned eoc_irq_valid_fall = 1;

	// stability timing: settle time after a running indication
	localparam int unsigned eoc_clk_mhz = 100;
	localparam int unsigned eoc_settle_us = 1;
	localparam int unsigned eoc_settle_cycles = eoc_settle_us * eoc_clk_mhz;

	// mode codes
	typedef enum logic [2:0] {
		eoc_mode_off0 = 3'h0,
		eoc_mode_off1 = 3'h1,
		eoc_mode_cmos = 3'h2,
		eoc_mode_cmos_div2 = 3'h3,
		eoc_mode_rc = 3'h4,
		eoc_mode_cap = 3'h5,
		eoc_mode_xtal = 3'h6,
		eoc_mode_xtal_div2 = 3'h7
	} eoc_mode_t;

	// analog circuit controls
	typedef struct packed {
		logic enable;
		logic cmos_in;
		logic rc_mode;
		logic cap_mode;
		logic xtal_mode;
		logic div2;
		logic [2:0] bias;
	} eoc_analog_t;

	// register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} eoc_bus_t;

endpackage

// file: logic/eoc_sync.sv
// Purpose: two-flop synchroniser for one level
// Assumes: input is asynchronous to ref_clk
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module eoc_sync
	import eoc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// level
	input wire logic din,
	output logic dout
);

	logic stage1;
	logic next_stage1;
	logic next_dout;

	always_comb begin
		next_stage1 = resetn ? din : 1'b0;
		next_dout = resetn ? stage1 : 1'b0;
	end

	always_ff @(posedge ref_clk) begin
		stage1 <= next_stage1;
		dout <= next_dout;
	end

endmodule // eoc_sync

// file: logic/eoc_settle.sv
// Purpose: declares the oscillator stable after a run of running cycles
// Assumes: running input already synchronised
// Notes: any drop of running or enable restarts the count
`timescale 1ns/100ps
module eoc_settle
	import eoc_pkg::*;
#(
	parameter int unsigned settle_cycles = eoc_settle_cycles
)(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// status
	input wire logic enable,
	input wire logic running,
	output logic stable
);

	localparam int unsigned cnt_w = $clog2(settle_cycles + 1);
	localparam logic [cnt_w-1:0] cnt_max = cnt_w'(settle_cycles);

	logic [cnt_w-1:0] count;
	logic [cnt_w-1:0] next_count;
	logic next_stable;

	always_comb begin
		next_count = count;
		next_stable = stable;
		if (!resetn || !enable || !running) begin
			next_count = '0;
			next_stable = 1'b0;
		end else if (count != cnt_max) begin
			next_count = count + cnt_w'(1);
		end else begin
			next_stable = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		count <= next_count;
		stable <= next_stable;
	end

endmodule // eoc_settle

// file: logic/eoc_top.sv
// Purpose: external oscillator control register, mode decode, valid flag
// Assumes: analog oscillator reports a running level on osc_running
// Notes: valid rise and fall events feed a masked level interrupt
//
// Chosen here: the plain strobed port.
`timescale 1ns/100ps

//
// Contract
// RULE1: valid reads zero in both cmos modes
// RULE2: otherwise valid means running and stable
// RULE3: mode in bits 6:4; 00x disables oscillator
// RULE4: 010 cmos input, 011 cmos divided by two
// RULE5: 100 rc mode, 101 capacitor mode
// RULE6: 110 crystal, 111 crystal divided by two
// RULE7: bit 3 reads zero; software writes zero
// RULE8: bits 2:0 set the bias current code
// RULE9: valid bit unwritable; drops when disabled
module eoc_top
	import eoc_pkg::*;
#(
	parameter int unsigned settle_cycles = eoc_settle_cycles
)(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// analog oscillator
	input wire logic osc_running,
	output eoc_analog_t analog_ctrl,
	// interrupt
	output logic irq
);

	eoc_bus_t bus;
	eoc_mode_t ext_osc_mode_sel;
	logic [2:0] ext_osc_bias_code;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic ext_clock_valid_flag;
	logic valid_q;
	logic running_sync;
	logic stable;
	logic osc_enabled;
	logic cmos_mode;
	logic [7:0] ext_osc_ctrl_reg;

	eoc_mode_t next_mode;
	logic [2:0] next_bias;
	logic [1:0] next_irq_stat;
	logic [1:0] next_irq_mask;
	logic next_valid_q;
	logic [7:0] next_rdata;
	eoc_analog_t next_analog;
	logic [1:0] events;

	always_comb begin
		bus.wr = reg_wr;
		bus.rd = reg_rd;
		bus.addr = reg_addr;
		bus.wdata = reg_wdata;
	end

	// mode decode
	always_comb begin
		osc_enabled = ext_osc_mode_sel[2:1] != 2'h0; // RULE3
		cmos_mode = ext_osc_mode_sel == eoc_mode_cmos ||
			ext_osc_mode_sel == eoc_mode_cmos_div2; // RULE4
	end

	eoc_sync u_run_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.din(osc_running),
		.dout(running_sync)
	);

	// cmos input has no amplifier to watch, so it never settles here
	eoc_settle #(
		.settle_cycles(settle_cycles)
	) u_settle (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.enable(osc_enabled && !cmos_mode),
		.running(running_sync),
		.stable(stable)
	);

	// combinational so a disabling write drops the flag at once
	always_comb begin
		ext_clock_valid_flag = stable && osc_enabled && // RULE2
			!cmos_mode; // RULE1 RULE9
		ext_osc_ctrl_reg = 8'h00;
		ext_osc_ctrl_reg[eoc_valid_bit] = ext_clock_valid_flag;
		ext_osc_ctrl_reg[eoc_mode_lsb +: 3] = ext_osc_mode_sel; // RULE3
		ext_osc_ctrl_reg[eoc_rsvd_bit] = 1'b0; // RULE7
		ext_osc_ctrl_reg[eoc_bias_lsb +: 3] = ext_osc_bias_code; // RULE8
	end

	// analog drive
	always_comb begin
		next_analog.enable = osc_enabled; // RULE3
		next_analog.cmos_in = cmos_mode; // RULE4
		next_analog.rc_mode = ext_osc_mode_sel == eoc_mode_rc; // RULE5
		next_analog.cap_mode = ext_osc_mode_sel == eoc_mode_cap; // RULE5
		next_analog.xtal_mode = ext_osc_mode_sel[2:1] == 2'h3; // RULE6
		next_analog.div2 = ext_osc_mode_sel == eoc_mode_cmos_div2 ||
			ext_osc_mode_sel == eoc_mode_xtal_div2; // RULE4 RULE6
		next_analog.bias = osc_enabled ? ext_osc_bias_code : 3'h0; // RULE8
		if (!resetn) begin
			next_analog = '0;
		end
	end

	// register writes; valid bit and bit 3 are dropped
	always_comb begin
		next_mode = ext_osc_mode_sel;
		next_bias = ext_osc_bias_code;
		next_irq_mask = irq_mask;
		next_valid_q = ext_clock_valid_flag;
		events = 2'h0;
		events[eoc_irq_valid_rise] = ext_clock_valid_flag && !valid_q;
		events[eoc_irq_valid_fall] = !ext_clock_valid_flag && valid_q;
		next_irq_stat = irq_stat;
		if (bus.wr && bus.addr == eoc_off_ctrl) begin
			next_mode = eoc_mode_t'(bus.wdata[eoc_mode_lsb +: 3]); // RULE3
			next_bias = bus.wdata[eoc_bias_lsb +: 3]; // RULE8
		end
		if (bus.wr && bus.addr == eoc_off_irq_mask) begin
			next_irq_mask = bus.wdata[1:0];
		end
		if (bus.wr && bus.addr == eoc_off_irq_stat) begin
			next_irq_stat = irq_stat & ~bus.wdata[1:0];
		end
		// set wins over a clear in the same cycle
		next_irq_stat = next_irq_stat | events;
		if (!resetn) begin
			next_mode = eoc_mode_t'(eoc_mode_rst);
			next_bias = eoc_bias_rst;
			next_irq_mask = eoc_irq_rst;
			next_irq_stat = eoc_irq_rst;
			next_valid_q = 1'b0;
		end
	end

	// read data, one cycle after the strobe, zero otherwise
	always_comb begin
		next_rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				eoc_off_ctrl: next_rdata = ext_osc_ctrl_reg; // RULE7
				eoc_off_irq_stat: next_rdata = {6'h00, irq_stat};
				eoc_off_irq_mask: next_rdata = {6'h00, irq_mask};
				default: next_rdata = 8'h00;
			endcase
		end
		if (!resetn) begin
			next_rdata = 8'h00;
		end
	end

	always_ff @(posedge ref_clk) begin
		ext_osc_mode_sel <= next_mode;
		ext_osc_bias_code <= next_bias;
		irq_mask <= next_irq_mask;
		irq_stat <= next_irq_stat;
		valid_q <= next_valid_q;
		reg_rdata <= next_rdata;
		analog_ctrl <= next_analog;
	end

	assign irq = |(irq_stat & irq_mask);

endmodule // eoc_top

// file: sim/eoc_top_asserts.sv
// Purpose: port checks for eoc_top
// Assumes: one clock, synchronous reset
// Notes: bound to every eoc_top
`timescale 1ns/100ps
module eoc_top_asserts
	import eoc_pkg::*;
#(
	parameter int unsigned settle_cycles = eoc_settle_cycles
)(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// analog oscillator
	input wire logic osc_running,
	input wire eoc_analog_t analog_ctrl,
	// interrupt
	input wire logic irq
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	logic rdc;
	always_ff @(posedge ref_clk) begin
		rdc <= resetn && reg_rd && reg_addr == eoc_off_ctrl;
	end
	// second cycle free of writes so the decode is not overwritten
	sequence s_wr(logic [1:0] md);
		reg_wr && reg_addr == eoc_off_ctrl && reg_wdata[6:5] == md ##1 !reg_wr;
	endsequence
	AST_OFF: assert property (s_wr(2'b00) |=> !analog_ctrl.enable)
		else $error("osc on while off");
	AST_CMOS: assert property (s_wr(2'b01) |=> analog_ctrl.cmos_in
		&& analog_ctrl.div2 == $past(reg_wdata[4], 2))
		else $error("cmos decode");
	AST_RC: assert property (s_wr(2'b10) |=>
		analog_ctrl.cap_mode == $past(reg_wdata[4], 2)
		&& analog_ctrl.rc_mode != $past(reg_wdata[4], 2))
		else $error("rc decode");
	AST_XTAL: assert property (s_wr(2'b11) |=> analog_ctrl.xtal_mode
		&& analog_ctrl.div2 == $past(reg_wdata[4], 2))
		else $error("xtal decode");
	AST_BIAS: assert property (reg_wr && reg_addr == eoc_off_ctrl
		&& reg_wdata[6] ##1 !reg_wr
		|=> analog_ctrl.bias == $past(reg_wdata[2:0], 2))
		else $error("bias code");
	AST_RSVD: assert property (rdc |-> !reg_rdata[3])
		else $error("reserved bit set");
	AST_VOFF: assert property (rdc && !reg_rdata[6]
		|-> !reg_rdata[7])
		else $error("valid in cmos or off");
	AST_VRUN: assert property (rdc && reg_rdata[7] |->
		$past(osc_running, settle_cycles + 1))
		else $error("valid without running");
	cover property (rdc && reg_rdata[7]);
	cover property (irq);
	cover property (s_wr(2'b01));
endmodule // eoc_top_asserts

bind eoc_top eoc_top_asserts #(.settle_cycles(settle_cycles)) i_chk (
	.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .osc_running, .analog_ctrl, .irq
);

// file: sim/eoc_osc_model.sv
// Purpose: external oscillator stand-in
// Assumes: starts some time after enable
// Notes: slow start mimics a crystal
`timescale 1ns/100ps
module eoc_osc_model
	import eoc_pkg::*;
(
	// analog side
	input wire eoc_analog_t analog_ctrl,
	input wire logic slow,
	output logic osc_running
);
	always begin
		osc_running = 1'b0;
		wait (analog_ctrl.enable);
		#(slow ? 473 : 37);
		osc_running = analog_ctrl.enable;
		wait (!analog_ctrl.enable);
	end
endmodule // eoc_osc_model

// file: sim/eoc_tb_top.sv
// Purpose: bench for eoc_top
// Assumes: settle_cycles shortened to 4
// Notes: each mode starts from off
`timescale 1ns/100ps
module eoc_tb_top
	import eoc_pkg::*;
;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic slow = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic osc_running;
	logic irq;
	eoc_analog_t analog_ctrl;
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int m, b, v;
	eoc_top #(.settle_cycles(4)) i_dut (
		.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .osc_running, .analog_ctrl, .irq
	);
	eoc_osc_model i_osc (.analog_ctrl, .slow, .osc_running);
	task automatic finish_test();
		if (n_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(n, reg_rdata, e);
		@(posedge ref_clk);
	endtask
	initial forever #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		void'($urandom(85));
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rd(eoc_off_ctrl, 8'h00, "ctrl");
		rd(8'hb2, 8'h00, "unmapped");
		for (m = 0; m < 8; m++) begin
			b = $urandom % 8;
			v = m / 4;
			slow <= m[0];
			wr(eoc_off_irq_mask, 8'(m / 2 % 2));
			rd(eoc_off_irq_mask, 8'(m / 2 % 2), "mask");
			// bit 7 set on purpose, must be dropped; bit 3 kept zero
			wr(eoc_off_ctrl, 8'(128 + m * 16 + b));
			rd(eoc_off_ctrl, 8'(m * 16 + b), "ctrl");
			repeat (80) @(posedge ref_clk);
			rd(eoc_off_ctrl, 8'(v * 128 + m * 16 + b), "ctrl");
			chk("irq", {7'h00, irq}, 8'(v * (m / 2 % 2)));
			rd(eoc_off_irq_stat, 8'(v), "stat");
			wr(eoc_off_ctrl, 8'h00);
			rd(eoc_off_ctrl, 8'h00, "ctrl");
			rd(eoc_off_irq_stat, 8'(v * 3), "stat");
			wr(eoc_off_irq_stat, 8'h03);
			rd(eoc_off_irq_stat, 8'h00, "stat");
			chk("irq", {7'h00, irq}, 8'h00);
		end
		finish_test();
	end
endmodule // eoc_tb_top
